// *** common/gas_param_defs.svh ***
// Offsets, codes and timing constants of the gas reading parameter map
`ifndef GAS_PARAM_DEFS_SVH
`define GAS_PARAM_DEFS_SVH

// Clock and serial link
`define CLK_HZ              200000000
`define BAUD_RATE           9600
`define NODE_ADDR           8'h01
`define FUNC_READ_HOLD      8'h03
`define FRAME_BITS          4'd11

// Times in milliseconds, with cycle counts derived from the clock rate
`define REFRESH_MS          2500
`define REFRESH_CYC         (`REFRESH_MS * (`CLK_HZ / 1000))
`define RESP_TIMEOUT_MS     1000
`define RESP_TIMEOUT_CYC    (`RESP_TIMEOUT_MS * (`CLK_HZ / 1000))
`define FLASH_HALF_MS       250
`define FLASH_HALF_CYC      (`FLASH_HALF_MS * (`CLK_HZ / 1000))
`define BAUD_CYC            (`CLK_HZ / `BAUD_RATE)

// Parameter map layout, byte offsets
`define OFS_PT1_YEAR            8'h00
`define OFS_PT1_MONTH           8'h02
`define OFS_PT1_SECOND          8'h0a
`define OFS_PT1_METHANE         8'h0c
`define OFS_PT1_CO2             8'h0e
`define OFS_PT1_OXYGEN          8'h10
`define OFS_PT1_INT_CELL        8'h12
`define OFS_PT1_EXT_CELL        8'h14
`define OFS_PT1_GAS_FLOW        8'h16
`define OFS_BARO_PRESSURE       8'h18
`define OFS_PT2_YEAR            8'h1a
`define OFS_PT2_MONTH           8'h1c
`define OFS_PT3_YEAR            8'h32
`define OFS_PT4_YEAR            8'h4a
`define OFS_ALARM_ONE           8'h62
`define OFS_ALARM_SIX           8'h6c
`define OFS_ALARM_SEVEN         8'h6e
`define OFS_GAP_FIRST           8'h70
`define OFS_ACTIVE_POINT        8'h80
`define WORD_COUNT              7'd65
`define WORD_LAST               7'd64

// Alarm state codes
`define ALARM_NONE              16'h0000
`define ALARM_TRIGGERED         16'h0001
`define ALARM_RECOVERY          16'h0002
`define ALARM_LATCHED           16'h0004
`define ALARM_MUTED             16'h0008
`define ALARM_TRIG_MUTED        16'h0009
`define ALARM_RECOV_MUTED       16'h000a

// Response frame: node, function, count, 130 data bytes, two check bytes
`define RESP_COUNT_BYTE         8'h82
`define RESP_DATA_FIRST         8'd3
`define RESP_LAST_IDX           8'd134
`define REQ_LAST_IDX            3'd7

// Consecutive failed polls after which the link counts as lost
`define LOST_FAILS              2'd3

`endif

// *** common/gas_param_pkg.sv ***
// Types shared by the gas reading parameter map
package gas_param_pkg;

    typedef enum logic [1:0] {
        POLL_IDLE,
        POLL_SEND,
        POLL_WAIT
    } poll_state_e;

    typedef logic [15:0] word_t;

endpackage

// *** rtl/gas_param_map.sv ***
// Serial-polling read-only parameter map for a fieldbus converter
//
// How it works
// - poll the analyser for all words once every 2.5 seconds
// - a failed or broken poll clears every stored word to zero
// - link lamp green when good, flashing red when intermittent, steady red when lost
// - poll node 1 at 9600 baud, even parity, one stop bit
// - act as slave to the network master, answering from polled data
// - each parameter is a 16-bit word at an even byte offset
// - offset pt1_year holds point one year in binary
// - offsets pt1_month to pt1_second hold point one month to second
// - offset pt1_methane_tenths holds point one methane in tenths of percent
// - offsets pt1_carbon_dioxide_tenths and pt1_oxygen_tenths hold point one CO2 and oxygen tenths
// - offset pt1_internal_cell_ppm holds point one internal cell in ppm
// - offset pt1_external_cell_ppm holds point one external cell in ppm
// - offset pt1_gas_flow holds point one gas flow in cc per minute
// - offset baro_pressure_mbar holds barometric pressure in millibar
// - point two group starts at pt2_year, same field order
// - alarm six and seven at alarm_six_state and alarm_seven_state, codes 9 and A
// - offset active_sample_point holds the active sample point, 1 to 4
// - alarm one to five at 0x0062 to 0x006A with codes 0,1,2,4,8
// - point three and four groups start at 0x0032 and 0x004A
`include "gas_param_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module gas_param_map
    import gas_param_pkg::*;
#(
    parameter int unsigned REFRESH_CYC      = `REFRESH_CYC,
    parameter int unsigned RESP_TIMEOUT_CYC = `RESP_TIMEOUT_CYC,
    parameter int unsigned FLASH_HALF_CYC   = `FLASH_HALF_CYC,
    parameter int unsigned BAUD_CYC         = `BAUD_CYC
)
(
    // Clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        RST_N,
    // Network read port
    input  wire logic        RD_EN,
    input  wire logic [7:0]  RD_ADDR,
    output var  logic [15:0] RDATA,
    output var  logic        RD_VALID,
    input  wire logic        WR_EN,
    output var  logic        WR_REFUSED,
    // Serial link to the analyser
    output var  logic        TX,
    input  wire logic        RX,
    // Link status lamp
    output var  logic        LED_GREEN,
    output var  logic        LED_RED
);

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++)
        begin
            r = r[0] ? ((r >> 1) ^ 16'ha001) : (r >> 1);
        end
        return r;
    endfunction

    // Only even offsets up to the active point word, minus the gap, are mapped
    function automatic logic addr_mapped(input logic [7:0] a);
        return !a[0] && (a <= `OFS_ACTIVE_POINT)
               && !((a >= `OFS_GAP_FIRST) && (a < `OFS_ACTIVE_POINT));
    endfunction

    poll_state_e  state;
    logic [31:0]  refresh_cnt;
    logic [31:0]  wait_cnt;
    logic         poll_go;
    logic         frame_good;
    logic         frame_bad;
    logic [1:0]   fail_run;
    logic [31:0]  flash_cnt;
    logic         flash_phase;

    word_t        shadow [0:64];
    word_t        live   [0:64];

    // Transmit side
    logic [2:0]   tx_idx;
    logic [15:0]  tx_crc;
    logic [10:0]  tx_shift;
    logic [3:0]   tx_bits;
    logic [31:0]  tx_baud;
    logic         tx_busy;
    logic         tx_done;

    // Receive side
    logic         rx_busy;
    logic [31:0]  rx_baud;
    logic [3:0]   rx_bits;
    logic [9:0]   rx_shift;
    logic         rx_strobe;
    logic         rx_bad;
    logic [7:0]   rx_byte;
    logic [7:0]   rx_idx;
    logic [15:0]  rx_crc;
    logic         rx_err;
    logic [7:0]   hi_byte;
    logic [6:0]   word_idx;

    // Refresh timer
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            refresh_cnt <= 32'h0;
            poll_go     <= 1'b0;
        end
        else if (refresh_cnt == REFRESH_CYC - 1)
        begin
            refresh_cnt <= 32'h0;
            poll_go     <= 1'b1;
        end
        else
        begin
            refresh_cnt <= refresh_cnt + 32'h1;
            poll_go     <= 1'b0;
        end
    end

    // Poll sequencer; a stalled reply ends the poll at the timeout
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            state    <= POLL_IDLE;
            wait_cnt <= 32'h0;
        end
        else
        begin
            case (state)
                POLL_IDLE:
                begin
                    wait_cnt <= 32'h0;
                    if (poll_go)
                        state <= POLL_SEND;
                end
                POLL_SEND:
                begin
                    if (tx_done)
                        state <= POLL_WAIT;
                end
                POLL_WAIT:
                begin
                    wait_cnt <= wait_cnt + 32'h1;
                    if (frame_good || frame_bad)
                        state <= POLL_IDLE;
                end
                default:
                    state <= POLL_IDLE;
            endcase
        end
    end

    // Request is node, function, start 0, count 65, then check word
    function automatic logic [7:0] req_byte(input logic [2:0] i, input logic [15:0] c);
        case (i)
            3'd0:    return `NODE_ADDR;
            3'd1:    return `FUNC_READ_HOLD;
            3'd5:    return {1'b0, `WORD_COUNT};
            3'd6:    return c[7:0];
            3'd7:    return c[15:8];
            default: return 8'h00;
        endcase
    endfunction

    // Serial transmitter, even parity, one stop bit
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            tx_idx   <= 3'd0;
            tx_crc   <= 16'hffff;
            tx_shift <= 11'h7ff;
            tx_bits  <= 4'd0;
            tx_baud  <= 32'h0;
            tx_busy  <= 1'b0;
            tx_done  <= 1'b0;
            TX       <= 1'b1;
        end
        else
        begin
            tx_done <= 1'b0;
            if (state != POLL_SEND)
            begin
                tx_idx  <= 3'd0;
                tx_crc  <= 16'hffff;
                tx_busy <= 1'b0;
                TX      <= 1'b1;
            end
            else if (!tx_busy && !tx_done)
            begin
                tx_shift <= {1'b1, ^req_byte(tx_idx, tx_crc), req_byte(tx_idx, tx_crc), 1'b0};
                if (tx_idx < 3'd6)
                    tx_crc <= crc_step(tx_crc, req_byte(tx_idx, tx_crc));
                tx_bits  <= 4'd0;
                tx_baud  <= 32'h0;
                tx_busy  <= 1'b1;
            end
            else if (tx_busy)
            begin
                TX <= tx_shift[0];
                if (tx_baud == BAUD_CYC - 1)
                begin
                    tx_baud  <= 32'h0;
                    tx_shift <= {1'b1, tx_shift[10:1]};
                    if (tx_bits == `FRAME_BITS - 4'd1)
                    begin
                        tx_busy <= 1'b0;
                        tx_idx  <= tx_idx + 3'd1;
                        tx_done <= (tx_idx == `REQ_LAST_IDX);
                    end
                    else
                        tx_bits <= tx_bits + 4'd1;
                end
                else
                    tx_baud <= tx_baud + 32'h1;
            end
        end
    end

    // Serial receiver, samples mid-bit; parity and stop bit checked
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            rx_busy   <= 1'b0;
            rx_baud   <= 32'h0;
            rx_bits   <= 4'd0;
            rx_shift  <= 10'h0;
            rx_strobe <= 1'b0;
            rx_bad    <= 1'b0;
            rx_byte   <= 8'h0;
        end
        else
        begin
            rx_strobe <= 1'b0;
            if (!rx_busy)
            begin
                rx_baud <= 32'h0;
                rx_bits <= 4'd0;
                rx_busy <= !RX;
            end
            else if (rx_bits == 4'd0 && rx_baud == BAUD_CYC / 2 - 1)
            begin
                rx_baud <= 32'h0;
                rx_bits <= 4'd1;
                rx_busy <= !RX;
            end
            else if (rx_bits != 4'd0 && rx_baud == BAUD_CYC - 1)
            begin
                rx_baud  <= 32'h0;
                rx_shift <= {RX, rx_shift[9:1]};
                if (rx_bits == `FRAME_BITS - 4'd1)
                begin
                    rx_busy   <= 1'b0;
                    rx_strobe <= 1'b1;
                    rx_byte   <= rx_shift[8:1];
                    rx_bad    <= !RX || (^rx_shift[9:1]);
                end
                else
                    rx_bits <= rx_bits + 4'd1;
            end
            else
                rx_baud <= rx_baud + 32'h1;
        end
    end

    // Reply parser; words land big-endian in the shadow copy
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            rx_idx     <= 8'h0;
            rx_crc     <= 16'hffff;
            rx_err     <= 1'b0;
            hi_byte    <= 8'h0;
            word_idx   <= 7'h0;
            frame_good <= 1'b0;
            frame_bad  <= 1'b0;
        end
        else
        begin
            frame_good <= 1'b0;
            frame_bad  <= 1'b0;
            if (state != POLL_WAIT || frame_good || frame_bad)
            begin
                rx_idx   <= 8'h0;
                rx_crc   <= 16'hffff;
                rx_err   <= 1'b0;
                word_idx <= 7'h0;
            end
            else if (wait_cnt == RESP_TIMEOUT_CYC - 1)
                frame_bad <= 1'b1;
            else if (rx_strobe)
            begin
                rx_idx <= rx_idx + 8'h1;
                rx_crc <= crc_step(rx_crc, rx_byte);
                if (rx_bad
                    || (rx_idx == 8'd0 && rx_byte != `NODE_ADDR)
                    || (rx_idx == 8'd1 && rx_byte != `FUNC_READ_HOLD)
                    || (rx_idx == 8'd2 && rx_byte != `RESP_COUNT_BYTE))
                    rx_err <= 1'b1;
                if (rx_idx >= `RESP_DATA_FIRST && rx_idx < `RESP_LAST_IDX - 8'd1)
                begin
                    if (rx_idx[0])
                        hi_byte <= rx_byte;
                    else
                    begin
                        shadow[word_idx] <= {hi_byte, rx_byte};
                        word_idx         <= word_idx + 7'h1;
                    end
                end
                if (rx_idx == `RESP_LAST_IDX)
                begin
                    // Check word folded into the CRC leaves zero on a clean frame
                    frame_good <= !rx_err && !rx_bad
                                  && crc_step(rx_crc, rx_byte) == 16'h0000;
                    frame_bad  <= rx_err || rx_bad
                                  || crc_step(rx_crc, rx_byte) != 16'h0000;
                end
            end
        end
    end

    // Good frame publishes all words at once; any failure zeroes them
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            for (int i = 0; i <= 64; i++)
                live[i] <= 16'h0;
        end
        else if (frame_good)
        begin
            for (int i = 0; i <= 64; i++)
                live[i] <= shadow[i];
        end
        else if (frame_bad)
        begin
            for (int i = 0; i <= 64; i++)
                live[i] <= 16'h0;
        end
    end

    // Network slave read port; writes only raise a refusal pulse
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            RDATA      <= 16'h0;
            RD_VALID   <= 1'b0;
            WR_REFUSED <= 1'b0;
        end
        else
        begin
            RD_VALID   <= RD_EN;
            WR_REFUSED <= WR_EN;
            if (RD_EN)
                RDATA <= addr_mapped(RD_ADDR) ? live[RD_ADDR[7:1]] : 16'h0;
        end
    end

    // Failure run; starts as lost until the first good poll
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
            fail_run <= `LOST_FAILS;
        else if (frame_good)
            fail_run <= 2'd0;
        else if (frame_bad && fail_run != `LOST_FAILS)
            fail_run <= fail_run + 2'd1;
    end

    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            flash_cnt   <= 32'h0;
            flash_phase <= 1'b0;
        end
        else if (flash_cnt == FLASH_HALF_CYC - 1)
        begin
            flash_cnt   <= 32'h0;
            flash_phase <= !flash_phase;
        end
        else
            flash_cnt <= flash_cnt + 32'h1;
    end

    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            LED_GREEN <= 1'b0;
            LED_RED   <= 1'b1;
        end
        else
        begin
            LED_GREEN <= (fail_run == 2'd0);
            LED_RED   <= (fail_run == `LOST_FAILS) || (fail_run != 2'd0 && flash_phase);
        end
    end

    a_poll_period: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        refresh_cnt < REFRESH_CYC)
        else $error("refresh counter ran past its period");

    a_fail_zeroes: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        frame_bad |=> live[0] == 16'h0 && live[6] == 16'h0 && live[64] == 16'h0)
        else $error("words not cleared after failed poll");

    a_good_commits: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        frame_good |=> live[0] == $past(shadow[0]) && live[64] == $past(shadow[64]))
        else $error("good poll did not publish words");

    a_good_green: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        frame_good |-> ##2 (LED_GREEN && !LED_RED))
        else $error("lamp not green after good poll");

    a_lost_red: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (fail_run == `LOST_FAILS) [*2] |-> (LED_RED && !LED_GREEN))
        else $error("lamp not steady red when link lost");

    a_read_answer: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        RD_EN && !frame_good && !frame_bad
        |=> RD_VALID && RDATA == (addr_mapped($past(RD_ADDR))
                                  ? live[$past(RD_ADDR[7:1])] : 16'h0))
        else $error("read answer wrong or late");

    a_odd_zero: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        RD_EN && RD_ADDR[0] |=> RDATA == 16'h0)
        else $error("odd offset returned data");

    a_write_ignored: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        WR_EN && !frame_good && !frame_bad |=> WR_REFUSED && $stable(live[0]))
        else $error("write changed stored words");

    a_tx_idle_high: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        state == POLL_IDLE |=> TX)
        else $error("serial line not idle high");

    c_good_poll: cover property (@(posedge SYS_CLK) disable iff (!RST_N) frame_good);
    c_bad_poll:  cover property (@(posedge SYS_CLK) disable iff (!RST_N) frame_bad);
    c_flashing:  cover property (@(posedge SYS_CLK) disable iff (!RST_N)
        fail_run == 2'd1 && LED_RED);
    c_read_live: cover property (@(posedge SYS_CLK) disable iff (!RST_N)
        RD_VALID && RDATA != 16'h0);

endmodule

`default_nettype wire

// *** dv/analyser_model.sv ***
// Behavioural analyser answering register polls on the serial link
`timescale 1ns/1ps
`default_nettype none

module analyser_model
    import gas_param_pkg::*;
#(
    parameter int BAUD = 8
)
(
    // Clock
    input  wire logic  clk,
    // Serial link
    input  wire logic  tx,
    output var  logic  rx,
    // Scenario control and readings
    input  wire logic  silent,
    input  var  word_t words [65],
    output var  logic  req_ok
);
    logic [7:0]  req [6] = '{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h41};
    logic [15:0] crc;
    logic [15:0] keep;
    logic [7:0]  b;
    logic        g;
    logic        acc;

    function automatic logic [15:0] step(logic [15:0] c, logic [7:0] d);
        c = c ^ {8'h00, d};
        repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
        return c;
    endfunction

    // Samples each bit mid-cell, as a real receiver would
    task automatic get_byte(output logic [7:0] d, output logic ok);
        logic p;
        @(negedge tx);
        repeat (BAUD / 2) @(posedge clk);
        for (int i = 0; i < 8; i++)
        begin
            repeat (BAUD) @(posedge clk);
            d[i] = tx;
        end
        repeat (BAUD) @(posedge clk);
        p = tx;
        repeat (BAUD) @(posedge clk);
        ok = (p == ^d) && tx;
    endtask

    task automatic put_byte(input logic [7:0] d);
        logic [10:0] f;
        f = {1'b1, ^d, d, 1'b0};
        for (int i = 0; i < 11; i++)
        begin
            rx <= f[i];
            repeat (BAUD) @(posedge clk);
        end
        crc = step(crc, d);
    endtask

    initial
    begin
        rx = 1'b1;
        req_ok = 1'b0;
        forever
        begin
            crc = 16'hffff;
            acc = 1'b1;
            for (int j = 0; j < 8; j++)
            begin
                get_byte(b, g);
                acc = acc && g && (j < 6 ? b == req[j] : b == crc[8*(j-6) +: 8]);
                if (j < 6)
                    crc = step(crc, b);
            end
            req_ok = acc;
            // A silent analyser is how a broken link shows at this side
            if (!silent)
            begin
                repeat (4 * BAUD) @(posedge clk);
                crc = 16'hffff;
                put_byte(8'h01);
                put_byte(8'h03);
                put_byte(8'h82);
                for (int k = 0; k < 65; k++)
                begin
                    put_byte(words[k][15:8]);
                    put_byte(words[k][7:0]);
                end
                keep = crc;
                put_byte(keep[7:0]);
                put_byte(keep[15:8]);
            end
        end
    end
endmodule

`default_nettype wire

// *** dv/tb_gas_param_map.sv ***
// Self-checking bench for the gas reading parameter map
`timescale 1ns/1ps
`default_nettype none

module tb_gas_param_map
    import gas_param_pkg::*;
;
    localparam int REFRESH = 20000;
    localparam int TMO     = 13000;
    localparam int FLASH   = 64;
    localparam int BAUD    = 8;
    localparam word_t ACODE [5] = '{16'h0000, 16'h0001, 16'h0002, 16'h0004, 16'h0008};

    logic        sys_clk = 1'b0;
    logic        rst_n   = 1'b0;
    logic        rd_en   = 1'b0;
    logic [7:0]  rd_addr = 8'h00;
    logic        wr_en   = 1'b0;
    logic        silent  = 1'b0;
    word_t       rdata;
    logic        rd_valid;
    logic        wr_refused;
    logic        tx;
    logic        rx;
    logic        led_green;
    logic        led_red;
    logic        req_ok;
    logic        flip;
    word_t       words [65];
    word_t       v;
    int          failures = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    int          idle = 0;
    int          starts [$];

    initial
    begin
        forever #2.5 sys_clk = ~sys_clk;
    end

    gas_param_map #(.REFRESH_CYC(REFRESH), .RESP_TIMEOUT_CYC(TMO), .FLASH_HALF_CYC(FLASH),
        .BAUD_CYC(BAUD)) DUT (.SYS_CLK(sys_clk), .RST_N(rst_n), .RD_EN(rd_en),
        .RD_ADDR(rd_addr), .RDATA(rdata), .RD_VALID(rd_valid), .WR_EN(wr_en),
        .WR_REFUSED(wr_refused), .TX(tx), .RX(rx), .LED_GREEN(led_green), .LED_RED(led_red));

    analyser_model #(.BAUD(BAUD)) partner (.clk(sys_clk), .tx(tx), .rx(rx), .silent(silent),
        .words(words), .req_ok(req_ok));

    // Poll starts are start bits after a long idle; the ceiling cuts a hang short
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        idle <= (tx === 1'b1) ? idle + 1 : 0;
        if (tx === 1'b0 && idle > 100)
            starts.push_back(cyc);
        if (cyc == 90000)
        begin
            failures++;
            $display("[ERR] %0t run too long", $time);
            close_out();
        end
    end

    task automatic close_out();
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input word_t seen, input word_t exp);
        samples_checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] %0t saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic rd(input logic [7:0] a, output word_t d);
        @(posedge sys_clk);
        #1 rd_en = 1'b1;
        rd_addr = a;
        @(posedge sys_clk);
        #1 rd_en = 1'b0;
        check(word_t'(rd_valid), 16'h0001);
        d = rdata;
    endtask

    task automatic spot(input logic [7:0] a, input word_t e);
        rd(a, v);
        check(v, e);
    endtask

    task automatic read_all(input logic live);
        for (int i = 0; i < 65; i++)
        begin
            rd(8'(2 * i), v);
            check(v, (live && (i < 56 || i > 63)) ? words[i] : 16'h0000);
        end
    endtask

    task automatic wait_green(input logic lvl, input int n);
        int k = 0;
        while (led_green !== lvl && k < n)
        begin
            @(posedge sys_clk);
            #1 k++;
        end
        check(word_t'(led_green), word_t'(lvl));
    endtask

    initial
    begin
        // Date words non-zero so a live link is visible to the master
        for (int i = 0; i < 65; i++)
            words[i] = 16'h0100 + 16'(i);
        words[0] = 16'h07e0;
        words[6] = 16'h0259;
        words[9] = 16'h03e8;
        words[11] = 16'h0122;
        words[12] = 16'h03e1;
        words[13] = 16'h07e0;
        words[25] = 16'h07e0;
        words[37] = 16'h07e0;
        for (int i = 0; i < 5; i++)
            words[49 + i] = ACODE[i];
        words[54] = 16'h0009;
        words[55] = 16'h000a;
        words[64] = 16'h0003;
        repeat (8) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        check(word_t'(tx), 16'h0001);
        check(word_t'(led_red), 16'h0001);
        check(word_t'(led_green), 16'h0000);
        spot(8'h00, 16'h0000);
        $display("test reset done");
        wait_green(1'b1, REFRESH + TMO);
        check(word_t'(req_ok), 16'h0001);
        read_all(1'b1);
        spot(8'h00, 16'h07e0);
        spot(8'h0a, words[5]);
        spot(8'h0c, 16'h0259);
        spot(8'h10, words[8]);
        spot(8'h12, 16'h03e8);
        spot(8'h14, words[10]);
        spot(8'h16, 16'h0122);
        spot(8'h18, 16'h03e1);
        spot(8'h1c, words[14]);
        spot(8'h4a, 16'h07e0);
        for (int i = 0; i < 5; i++)
            spot(8'h62 + 8'(2 * i), ACODE[i]);
        spot(8'h6c, 16'h0009);
        spot(8'h6e, 16'h000a);
        spot(8'h80, 16'h0003);
        spot(8'h01, 16'h0000);
        spot(8'h81, 16'h0000);
        @(posedge sys_clk);
        #1 wr_en = 1'b1;
        @(posedge sys_clk);
        #1 wr_en = 1'b0;
        check(word_t'(wr_refused), 16'h0001);
        spot(8'h00, 16'h07e0);
        $display("test map done");
        silent = 1'b1;
        wait_green(1'b0, REFRESH + TMO);
        read_all(1'b0);
        v = word_t'(led_red);
        flip = 1'b0;
        repeat (FLASH + 2)
        begin
            @(posedge sys_clk);
            #1 if (led_red !== v[0])
                flip = 1'b1;
        end
        check(word_t'(flip), 16'h0001);
        check(word_t'(starts.size() > 1 ? starts[1] - starts[0] : 0), word_t'(REFRESH));
        $display("test loss done");
        silent = 1'b0;
        words[0] = 16'h07e1;
        wait_green(1'b1, REFRESH + TMO);
        spot(8'h00, 16'h07e1);
        $display("test recovery done");
        close_out();
    end
endmodule

`default_nettype wire
